// ### hdl/adc_conv_end.sv
/*
  converter end of the link: edge counting, successive approximation,
  serial result shifting, output float and normal/shutdown mode.
  assumes the link clock runs only during frames and that the analog
  level arrives as a slowly moving quantity in half-step units.
*/
`timescale 1ns/1ps
// Behaviour
// - select fall holds sample, drives output
// - count clock edges from select fall
// - return to tracking on 13th rise
// - host waits 350ns after 13th rise
// - float after 16th fall or select rise
// - host waits quiet time between conversions
// - host gives sixteen clocks per frame, four in a shutdown frame
// - change on fall, host captures next fall
// - three zeros then twelve bits, MSB first
// - host allows extra leading zero
// - host spaces select falls per frame math
// - host prefers twenty-clock frames; host end gives sixteen
// - straight binary, first step half LSB
// - select fall forces normal mode
// - rise between second and tenth fall means shutdown
// - shutdown holds until select falls
// - rise before second fall keeps mode
// - rise after tenth fall aborts, normal
// - host flags first result after wake as dummy
module adc_conv_end (
  // system side
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // analog level in half-step units
  input  wire adc_link_pkg::level_t  analog_level,
  // status
  output logic                       tracking,
  output logic                       shutdown,
  // link
  adc_link_if.device                 link
);

  // link-side state on rising clock edges
  typedef struct packed {
    adc_link_pkg::edge_cnt_t cnt;
    adc_link_pkg::code_t     sar;
    logic                    track;
  } rise_s;

  // link-side state on falling clock edges
  typedef struct packed {
    adc_link_pkg::edge_cnt_t cnt;
    logic                    sdo;
    logic                    done;
  } fall_s;

  // system-side state
  typedef struct packed {
    adc_link_pkg::level_t lvl_s1;
    adc_link_pkg::level_t lvl_s2;
    logic                 hold_s1;
    logic                 hold_s2;
    logic                 sel_s1;
    logic                 sel_s2;
    logic                 shut_s1;
    logic                 shut_s2;
    adc_link_pkg::code_t  sample;
    logic                 tracking;
    logic                 shutdown;
  } sys_s;

  rise_s rise_r;
  rise_s rise_nxt;
  fall_s fall_r;
  fall_s fall_nxt;
  logic  shut_r;
  logic  shut_nxt;
  sys_s  sys_r;
  sys_s  sys_nxt;
  logic  frame_rst_n;
  logic  hold_lvl;

  // frame state is cleared whenever select is high
  assign frame_rst_n = rst_n & ~link.frame_sel_n;

  // sampling switch open from select fall to the tracking rise
  assign hold_lvl = ~link.frame_sel_n & ~rise_r.track;

  // successive approximation on rising edges
  always_comb begin
    adc_link_pkg::edge_cnt_t n;
    adc_link_pkg::edge_cnt_t k;
    adc_link_pkg::code_t     trial;
    n        = rise_r.cnt + 5'h01;
    k        = adc_link_pkg::TRACK_RISE - n;
    trial    = rise_r.sar | (adc_link_pkg::code_t'(1) << k[3:0]);
    rise_nxt = rise_r;
    if (!fall_r.done && rise_r.cnt != adc_link_pkg::FRAME_FALLS) begin
      rise_nxt.cnt = n;
      if (n >= adc_link_pkg::FIRST_SAR_RISE &&
          n <= adc_link_pkg::TRACK_RISE) begin
        if (sys_r.sample >= trial) begin
          rise_nxt.sar = trial;
        end
      end
      if (n == adc_link_pkg::TRACK_RISE) begin
        rise_nxt.track = 1'b1;
      end
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // result shifting on falling edges
  always_comb begin
    adc_link_pkg::edge_cnt_t n;
    adc_link_pkg::edge_cnt_t idx;
    n        = fall_r.cnt + 5'h01;
    idx      = adc_link_pkg::LAST_DATA_FALL - n;
    fall_nxt = fall_r;
    if (!fall_r.done) begin
      fall_nxt.cnt = n;
      if (n >= adc_link_pkg::FIRST_DATA_FALL &&
          n <= adc_link_pkg::LAST_DATA_FALL) begin
        fall_nxt.sdo = rise_r.sar[idx[3:0]];
      end else begin
        fall_nxt.sdo = 1'b0;
      end
      if (n == adc_link_pkg::FRAME_FALLS) begin
        fall_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_r <= '0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  // mode to take if select rises now; survives select high
  always_comb begin
    adc_link_pkg::edge_cnt_t n;
    n        = fall_r.cnt + 5'h01;
    shut_nxt = shut_r;
    if (!link.frame_sel_n && !fall_r.done) begin
      if (n >= adc_link_pkg::NORMAL_FALL) begin
        shut_nxt = 1'b0;
      end else if (n >= adc_link_pkg::SHUT_FIRST_FALL) begin
        shut_nxt = 1'b1;
      end
    end
  end

  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      shut_r <= 1'b0;
    end else begin
      shut_r <= shut_nxt;
    end
  end

  // line driven from select fall until done or select rise
  assign link.serial_result_out      = fall_r.sdo;
  assign link.serial_result_out_oe_n =
    link.frame_sel_n | fall_r.done;

  // system side: level tracking, hold and mode status
  always_comb begin
    sys_nxt         = sys_r;
    sys_nxt.lvl_s1  = analog_level;
    sys_nxt.lvl_s2  = sys_r.lvl_s1;
    sys_nxt.hold_s1 = hold_lvl;
    sys_nxt.hold_s2 = sys_r.hold_s1;
    sys_nxt.sel_s1  = link.frame_sel_n;
    sys_nxt.sel_s2  = sys_r.sel_s1;
    sys_nxt.shut_s1 = shut_r;
    sys_nxt.shut_s2 = sys_r.shut_s1;
    if (!sys_r.hold_s2) begin
      sys_nxt.sample = adc_link_pkg::level_to_code(sys_r.lvl_s2);
    end
    sys_nxt.tracking = ~sys_r.hold_s2;
    sys_nxt.shutdown = sys_r.sel_s2 & sys_r.shut_s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= '0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // status outputs
  assign tracking = sys_r.tracking;
  assign shutdown = sys_r.shutdown;

endmodule // adc_conv_end

// ### hdl/adc_host_end.sv
/*
  host end of the link: makes the serial clock by dividing clk,
  frames conversions, captures the result and spaces frames.
  assumes a 200 MHz clk; the converter floats the line outside frames.
*/
`timescale 1ns/1ps
module adc_host_end (
  // system side
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // requests
  input  wire logic                 start,
  input  wire logic                 shutdown_req,
  // answers
  output logic                      busy,
  output adc_link_pkg::code_t       result,
  output logic                      result_valid,
  output logic                      result_dummy,
  // link
  adc_link_if.host                  link
);

  typedef struct packed {
    adc_link_pkg::host_state_e st;
    logic [1:0]                div;
    adc_link_pkg::edge_cnt_t   falls;
    logic                      sclk;
    logic                      sel_n;
    adc_link_pkg::code_t       shreg;
    adc_link_pkg::code_t       result;
    logic                      valid;
    logic                      dummy;
    logic                      wake;
    logic                      sd_s1;
    logic                      sd_s2;
    logic [6:0]                quiet;
    logic                      shut;
    logic                      busy;
  } host_s;

  host_s r;
  host_s nxt;

  // frame sequencing
  always_comb begin
    adc_link_pkg::edge_cnt_t n;
    n         = r.falls + 5'h01;
    nxt       = r;
    nxt.valid = 1'b0;
    nxt.sd_s1 = link.serial_result_line;
    nxt.sd_s2 = r.sd_s1;
    case (r.st)
      adc_link_pkg::H_IDLE: begin
        if (start) begin
          nxt.sel_n = 1'b0;
          nxt.falls = adc_link_pkg::EDGE_NONE;
          nxt.div   = 2'h0;
          nxt.shut  = shutdown_req;
          nxt.busy  = 1'b1;
          nxt.st    = adc_link_pkg::H_FRAME;
        end
      end
      adc_link_pkg::H_FRAME: begin
        nxt.div = r.div + 2'h1;
        if (r.div == adc_link_pkg::SCLK_HALF_LAST) begin
          nxt.div = 2'h0;
          if (r.sclk) begin
            // clock idles high, so no extra leading zero appears
            nxt.sclk  = 1'b0;
            nxt.falls = n;
            if (n >= adc_link_pkg::FIRST_CAPT_FALL &&
                n <= adc_link_pkg::LAST_CAPT_FALL) begin
              nxt.shreg = {r.shreg[10:0], r.sd_s2};
            end
          end else begin
            nxt.sclk = 1'b1;
            if (r.falls == adc_link_pkg::FRAME_FALLS) begin
              nxt.sel_n  = 1'b1;
              nxt.result = r.shreg;
              nxt.valid  = 1'b1;
              nxt.dummy  = r.wake;
              nxt.wake   = 1'b0;
              nxt.quiet  = 7'h00;
              nxt.st     = adc_link_pkg::H_QUIET;
            end else if (r.shut &&
                         r.falls == adc_link_pkg::HOST_SHUT_FALL) begin
              nxt.sel_n = 1'b1;
              nxt.wake  = 1'b1;
              nxt.quiet = 7'h00;
              nxt.st    = adc_link_pkg::H_QUIET;
            end
          end
        end
      end
      adc_link_pkg::H_QUIET: begin
        nxt.quiet = r.quiet + 7'h01;
        if (r.quiet == adc_link_pkg::QUIET_LAST) begin
          nxt.busy = 1'b0;
          nxt.st   = adc_link_pkg::H_IDLE;
        end
      end
      default: begin
        nxt.st = adc_link_pkg::H_IDLE;
      end
    endcase
  end

  // state register; first result after power-up is a dummy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.sclk  <= 1'b1;
      r.sel_n <= 1'b1;
      r.wake  <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  // outputs
  assign link.frame_sel_n = r.sel_n;
  assign link.sclk        = r.sclk;
  assign busy             = r.busy;
  assign result           = r.result;
  assign result_valid     = r.valid;
  assign result_dummy     = r.dummy;

endmodule // adc_host_end

// ### hdl/adc_link_if.sv
/*
  the three-wire link between the converter and its host: frame select,
  serial clock and the shared result line.
  assumes the host drives select and clock; the converter drives the
  result line only while its enable is low, and a released line shows
  the inverse of the last bit.
*/
`timescale 1ns/1ps
interface adc_link_if;

  // link wires
  logic frame_sel_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_out_oe_n;
  wire  serial_result_line;

  // released line inverts the last bit so a late capture cannot pass
  assign serial_result_line =
    serial_result_out_oe_n ? ~serial_result_out : serial_result_out;

  modport device (
    input  frame_sel_n,
    input  sclk,
    output serial_result_out,
    output serial_result_out_oe_n
  );

  modport host (
    output frame_sel_n,
    output sclk,
    input  serial_result_line
  );

endinterface

// ### hdl/adc_link_pkg.sv
/*
  shared constants, types and helpers for the serial converter link:
  frame edge positions, result layout, host timing and level coding.
  assumes a 200 MHz system clock on the host side and a link clock
  that runs only while a frame is open.
*/
package adc_link_pkg;

  // result layout
  localparam int unsigned RESULT_BITS = 12;
  typedef logic [RESULT_BITS-1:0] code_t;
  typedef logic [RESULT_BITS:0]   level_t;   // input level in half steps
  typedef logic [4:0]             edge_cnt_t;

  localparam code_t     CODE_MAX    = 12'hFFF;
  localparam code_t     CODE_RESET  = 12'h000;
  localparam level_t    LEVEL_RESET = 13'h0000;

  // edge positions inside a frame, counted from the select fall
  localparam edge_cnt_t EDGE_NONE       = 5'h00;
  localparam edge_cnt_t FIRST_SAR_RISE  = 5'h02;
  localparam edge_cnt_t TRACK_RISE      = 5'h0D;
  localparam edge_cnt_t FIRST_DATA_FALL = 5'h03;
  localparam edge_cnt_t LAST_DATA_FALL  = 5'h0E;
  localparam edge_cnt_t SHUT_FIRST_FALL = 5'h02;
  localparam edge_cnt_t NORMAL_FALL     = 5'h0A;
  localparam edge_cnt_t FRAME_FALLS     = 5'h10;

  // host capture window and early-raise point for shutdown
  localparam edge_cnt_t FIRST_CAPT_FALL = 5'h04;
  localparam edge_cnt_t LAST_CAPT_FALL  = 5'h0F;
  localparam edge_cnt_t HOST_SHUT_FALL  = 5'h04;

  // host timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ACQ_TIME_NS   = 350;
  localparam int unsigned ACQ_CYCLES_I  =
    (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0]  QUIET_LAST    = 7'(ACQ_CYCLES_I - 1);
  localparam logic [1:0]  SCLK_HALF_LAST = 2'h2;   // three clk per half

  typedef enum logic [1:0] {H_IDLE, H_FRAME, H_QUIET} host_state_e;

  // half-step level to straight binary code, first step at half a step
  function automatic code_t level_to_code(input level_t lvl);
    logic [RESULT_BITS+1:0] sum;
    sum = {1'b0, lvl} + 14'h0001;
    if (sum[RESULT_BITS+1])
      level_to_code = CODE_MAX;
    else
      level_to_code = sum[RESULT_BITS:1];
  endfunction

endpackage

// ### test/adc_link_assertions.sv
/*
  link checker: timing and framing assertions on the converter link.
  assumes both ends share clk and rst_n; sclk is a host register.
*/
`timescale 1ns/1ps
module adc_link_assertions (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_out_oe_n
);
  logic       sclk_r;
  logic [4:0] falls_r;
  logic [6:0] high_cnt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // falls in frame and cycles deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r       <= 1'b1;
      falls_r      <= 5'h00;
      high_cnt_r   <= 7'h7F;
    end else begin
      sclk_r       <= sclk;
      falls_r      <= frame_sel_n ? 5'h00 :
                      falls_r + 5'(sclk_r & ~sclk);
      high_cnt_r   <= !frame_sel_n ? 7'h00 :
                      high_cnt_r + 7'(high_cnt_r != 7'h7F);
    end
  end

  // sixteenth fall of the frame
  sequence s_last_fall;
    $fell(sclk) && falls_r == 5'h0F;
  endsequence

  a_select_drives_line: assert property ($fell(frame_sel_n) |->
    !serial_result_out_oe_n) else $error("line not driven at select");
  a_idle_line_floats: assert property (frame_sel_n |->
    serial_result_out_oe_n) else $error("line driven while deselected");
  a_float_after_last: assert property (s_last_fall |->
    ##[1:3] serial_result_out_oe_n) else $error("no float after fall 16");
  // falls_r lags one fall; add the fall seen at this edge
  a_leading_zeros: assert property (!serial_result_out_oe_n &&
    (falls_r + 5'($fell(sclk))) < 5'h03 |-> !serial_result_out)
    else $error("lead bit not 0");
  a_trailing_zero: assert property (s_last_fall |->
    !serial_result_out) else $error("trailing bit not 0");
  a_change_after_fall: assert property (!serial_result_out_oe_n &&
    !$past(serial_result_out_oe_n) && $changed(serial_result_out)
    |-> $fell(sclk)) else $error("bit changed off the fall");
  a_quiet_spacing: assert property ($fell(frame_sel_n) |->
    high_cnt_r >= 7'h46) else $error("quiet time too short");
  a_full_frame: assert property ($rose(frame_sel_n) &&
    falls_r > 5'h09 |-> falls_r == 5'h10) else $error("frame not 16");
  a_shut_window: assert property ($rose(frame_sel_n) &&
    falls_r < 5'h0A |-> falls_r >= 5'h02) else $error("early raise");
  a_clock_idles_high: assert property (frame_sel_n |->
    sclk) else $error("clock low outside frame");
endmodule // adc_link_assertions

// ### test/tb_serial_sar_adc_readout.sv
/*
  bench: host end drives converter end; a second converter end is
  driven by the bench to raise select at chosen falls.
  assumes 200 MHz clk; the host divides it down for the link clock.
*/
`timescale 1ns/1ps
module tb_serial_sar_adc_readout;
  logic                 clk;
  logic                 rst_n;
  adc_link_pkg::level_t level;
  logic                 start;
  logic                 shut_req;
  logic                 busy;
  adc_link_pkg::code_t  result;
  logic                 valid;
  logic                 dummy;
  logic                 tracking;
  logic                 shutdown;
  logic                 shutdown_b;
  logic [15:0]          word;
  int                   fails;
  int                   check_count;
  int                   cycles;

  adc_link_if link ();
  adc_link_if link_b ();

  adc_host_end adc_host_end_inst (.clk(clk), .rst_n(rst_n), .start(start),
    .shutdown_req(shut_req), .busy(busy), .result(result),
    .result_valid(valid), .result_dummy(dummy), .link(link));
  adc_conv_end adc_conv_end_inst (.clk(clk), .rst_n(rst_n),
    .analog_level(level), .tracking(tracking), .shutdown(shutdown),
    .link(link));
  adc_conv_end adc_conv_end_inst_b (.clk(clk), .rst_n(rst_n),
    .analog_level(level), .tracking(), .shutdown(shutdown_b),
    .link(link_b));
  adc_link_assertions adc_link_assertions_inst (.clk(clk), .rst_n(rst_n),
    .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
    .serial_result_out(link.serial_result_out),
    .serial_result_out_oe_n(link.serial_result_out_oe_n));

  // clock
  always #2.5 clk = ~clk;

  // line capture on every fall inside a frame
  always @(negedge link.sclk)
    if (!link.frame_sel_n)
      word <= {word[14:0], link.serial_result_line};

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic convert(input adc_link_pkg::level_t lvl, input logic sh,
                         input logic dm);
    logic [13:0] s;
    logic [11:0] code;
    int          n;
    s = ({1'b0, lvl} + 14'h0001) >> 1;
    code = s[12] ? 12'hFFF : s[11:0];
    level = lvl;
    shut_req = sh;
    repeat (4) @(negedge clk);
    word = 16'h0000;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (10) @(negedge clk);
    check("hold", 16'(tracking), 16'h0000);
    n = 0;
    while (busy && !valid && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (!sh) begin
      check("result", 16'(result), 16'(code));
      check("word", word, {3'h0, code, 1'h0});
    end
    if (dm !== 1'bx)
      check("dummy", 16'(dummy), 16'(dm));
    while (busy && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("track", 16'(tracking), 16'h0001);
    check("mode", 16'(shutdown), 16'(sh));
    check("float", 16'(link.serial_result_out_oe_n), 16'h0001);
  endtask

  task automatic frame_b(input int n, input logic mode);
    link_b.frame_sel_n = 1'b0;
    repeat (n) begin
      repeat (3) @(negedge clk);
      link_b.sclk = 1'b0;
      repeat (3) @(negedge clk);
      link_b.sclk = 1'b1;
    end
    repeat (3) @(negedge clk);
    link_b.frame_sel_n = 1'b1;
    #1 check("abort", 16'(link_b.serial_result_out_oe_n), 16'h0001);
    repeat (80) @(negedge clk);
    check("mode_b", 16'(shutdown_b), 16'(mode));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    adc_link_pkg::level_t lv[6];
    int                   nf[4];
    logic                 md[4];
    lv = '{13'h0000, 13'h0001, 13'h0002, 13'h0AAB, 13'h1FFE, 13'h1FFF};
    nf = '{5, 1, 12, 1};
    md = '{1'b1, 1'b1, 1'b0, 1'b0};
    clk = 1'b0;
    rst_n = 1'b0;
    level = 13'h0000;
    start = 1'b0;
    shut_req = 1'b0;
    word = 16'h0000;
    fails = 0;
    check_count = 0;
    cycles = 0;
    link_b.frame_sel_n = 1'b1;
    link_b.sclk = 1'b1;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    foreach (lv[i])
      convert(lv[i], 1'b0, (i == 0));
    $display("test codes done");
    convert(13'h0155, 1'b1, 1'bx);
    convert(13'h0155, 1'b0, 1'b1);
    convert(13'h0FFF, 1'b0, 1'b0);
    $display("test shutdown done");
    foreach (nf[i])
      frame_b(nf[i], md[i]);
    $display("test abort done");
    tally_and_finish();
  end
endmodule // tb_serial_sar_adc_readout
